//--- dfcd_host_model.sv
// Host model: serial master that issues frames to the decoder.
// Assumes the decoder clock; serial edges sit two or more clocks apart, except the data flip made together with the deselect.

`timescale 1ns/1ps
`default_nettype none

module dfcd_host_model (
   // System
   input wire logic clock,
   // Serial pins
   output logic sclk,
   output logic mosi,
   output logic csN,
   input wire logic miso
);

   initial begin
      sclk = 1'b0;
      mosi = 1'b1;
      csN = 1'b1;
   end

   // ------------------------------------------------------------------
   // Timing helper
   // ------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // ------------------------------------------------------------------
   // Frame transfer, MSB first
   // ------------------------------------------------------------------
   // Short counts are allowed on purpose so that refused frames can be sent
   task automatic xfer(input logic [15:0] cmd, input int nBits, output logic [15:0] resp);
      resp = 16'h0000;
      tick(1);
      csN = 1'b0;
      tick(4);
      for (int i = 15; i > 15 - nBits; i--) begin
         mosi = cmd[i];
         tick(2);
         resp[i] = miso;
         sclk = 1'b1;
         tick(2);
         sclk = 1'b0;
         tick(3);
      end
      csN = 1'b1;
      // Deselected data line must not look stable to the device
      mosi = ~mosi;
      tick(4);
   endtask

endmodule

`default_nettype wire

//--- dfcd_ol_filter.sv
// Open-load fault delay timer, restarted by every chip-select release.
// Assumes csRise is a one-cycle pulse in the clock domain.

`timescale 1ns/1ps
`default_nettype none

module dfcd_ol_filter
   import dfcd_pkg::*;
#(
   parameter logic [TIMER_W-1:0] FILTER_CYCLES = TIMER_W'(OL_FILTER_CYC)
)
(
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic csRise,
   output logic armed
);

   typedef enum logic [1:0] {OL_IDLE, OL_WAIT, OL_ARMED} dfcd_olst_t;

   dfcd_olst_t state_q, state_d;
   logic [TIMER_W-1:0] count_q, count_d;

   assign armed = (state_q == OL_ARMED);

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         OL_IDLE: begin
            count_d = '0;
         end
         OL_WAIT: begin
            count_d = count_q + 16'h0001;
            if (count_q + 16'h0001 >= FILTER_CYCLES) begin
               state_d = OL_ARMED;
            end
         end
         OL_ARMED: begin
            count_d = count_q;
         end
         default: begin
            state_d = OL_IDLE;
            count_d = '0;
         end
      endcase
      // A new release always restarts the delay
      if (csRise) begin
         state_d = OL_WAIT;
         count_d = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= OL_IDLE;
         count_q <= '0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

endmodule

`default_nettype wire

//--- dfcd_pkg.sv
// Shared constants and types for the driver fault command decoder.
// Assumes a 16-bit serial frame, command code in the top five bits.

`default_nettype none

package dfcd_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_W = 16;
   localparam int CMD_W = 5;
   localparam int CMD_HI = 15;
   localparam int CMD_LO = 11;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] FRAME_BITS = 5'h10;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [CMD_W-1:0] CMD_DRV2_CTRL = 5'h18;
   localparam logic [CMD_W-1:0] CMD_DRV2_DITHER = 5'h19;
   localparam logic [CMD_W-1:0] CMD_THERMAL_LIMIT_QUERY = 5'h1c;
   localparam logic [CMD_W-1:0] CMD_INVALID_A = 5'h1d;
   localparam logic [CMD_W-1:0] CMD_INVALID_B = 5'h1e;

   // ----------------------------------------------------------------
   // Command fields
   // ----------------------------------------------------------------
   localparam int CTRL_W = 11;
   localparam int RETRY_BIT = 10;
   localparam int AMP_HI = 6;
   localparam int AMP_LO = 4;
   localparam int AMP_W = 3;
   localparam int FREQ_HI = 3;
   localparam int FREQ_LO = 0;
   localparam int FREQ_W = 4;

   // ----------------------------------------------------------------
   // Response layout
   // ----------------------------------------------------------------
   localparam int NUM_OSS = 8;
   localparam int RESP_FAULT_BIT = 15;
   localparam int RESP_TRIM_BIT = 14;
   localparam int THERMAL_LIMIT_DRV1_BIT = 9;
   localparam int THERMAL_LIMIT_OSS_LO = 1;
   localparam int RESP_OL_LO = 0;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [NUM_OSS-1:0] PD_RESET = 8'hff;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
   localparam int CLK_MHZ = 125;
   localparam int OL_FILTER_MIN_US = 100;
   localparam int OL_FILTER_MAX_US = 450;
   localparam int OL_FILTER_CYC = OL_FILTER_MIN_US * CLK_MHZ;
   localparam int TIMER_W = 16;

   typedef enum logic {DFCD_RESP_NORMAL, DFCD_RESP_THERMAL_LIMIT} dfcd_resp_t;

endpackage

`default_nettype wire

//--- dfcd_spi_shift.sv
// Serial slave shifter for 16-bit command and response frames.
// Assumes clock, data and chip select are synchronous to clock.

`timescale 1ns/1ps
`default_nettype none

module dfcd_spi_shift
   import dfcd_pkg::*;
(
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Serial pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic csN,
   output logic miso,
   output logic misoOe,
   // Frame side
   input wire logic [FRAME_W-1:0] loadWord,
   output logic csFall,
   output logic csRise,
   output logic frameDone,
   output logic [FRAME_W-1:0] frameWord
);

   logic sclkPrev_q, sclkPrev_d;
   logic csPrev_q, csPrev_d;
   logic [FRAME_W-1:0] rxShift_q, rxShift_d;
   logic [FRAME_W-1:0] txShift_q, txShift_d;
   logic [BIT_CNT_W-1:0] bitCnt_q, bitCnt_d;
   logic miso_q, miso_d;
   logic sclkRise, sclkFall;

   assign sclkRise = sclk & ~sclkPrev_q;
   assign sclkFall = ~sclk & sclkPrev_q;
   assign csFall = ~csN & csPrev_q;
   assign csRise = csN & ~csPrev_q;
   // A frame counts only when at least sixteen clocks were seen (the count holds at sixteen)
   assign frameDone = csRise && (bitCnt_q == FRAME_BITS);
   assign frameWord = rxShift_q;
   assign miso = miso_q;
   assign misoOe = ~csN;

   always_comb begin
      sclkPrev_d = sclk;
      csPrev_d = csN;
      rxShift_d = rxShift_q;
      txShift_d = txShift_q;
      bitCnt_d = bitCnt_q;
      miso_d = miso_q;
      if (csFall) begin
         txShift_d = {loadWord[FRAME_W-2:0], 1'b0};
         miso_d = loadWord[FRAME_W-1];
         bitCnt_d = '0;
      end else if (!csN) begin
         if (sclkRise) begin
            rxShift_d = {rxShift_q[FRAME_W-2:0], mosi};
            if (bitCnt_q != FRAME_BITS) begin
               bitCnt_d = bitCnt_q + 5'h01;
            end
         end
         if (sclkFall) begin
            miso_d = txShift_q[FRAME_W-1];
            txShift_d = {txShift_q[FRAME_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sclkPrev_q <= 1'b0;
         csPrev_q <= 1'b1;
         rxShift_q <= '0;
         txShift_q <= '0;
         bitCnt_q <= '0;
         miso_q <= 1'b0;
      end else begin
         sclkPrev_q <= sclkPrev_d;
         csPrev_q <= csPrev_d;
         rxShift_q <= rxShift_d;
         txShift_q <= txShift_d;
         bitCnt_q <= bitCnt_d;
         miso_q <= miso_d;
      end
   end

endmodule

`default_nettype wire

//--- dfcd_top.sv
// Command decode, fault response and supply supervision of the driver.
// Assumes supply and comparator flags are synchronous digital levels.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Second driver dither command stores retry bit 10, amplitude and frequency.
// - Thermal query answer holds first driver and eight low-side switch faults.
// - Every response status bit except the trim bit is one for fault, zero for none.
// - Over-voltage bit reads one while battery supply is over-voltage.
// - Trim bit reads zero untrimmed, one once trimmed.
// - Open-load detection only while output off, one comparator per output.
// - Pull-downs enabled at power-up; detection needs the pull-down.
// - Disabled pull-down forces that output's open-load bit to zero.
// - Pull-down switched off only in sleep or by serial command.
// - Open-load faults filtered between 100 and 450 microseconds.
// - Chip-select rise starts the timer; comparator enabled after expiry.
// - Open-load bit stays latched until the host has read it.
// - Logic or battery under-voltage shuts outputs and resets control registers.
// - Low battery above under-voltage keeps outputs following commands.
// - Battery over-voltage shuts outputs until supply returns to normal.
module dfcd_top
   import dfcd_pkg::*;
#(
   parameter logic [TIMER_W-1:0] OL_FILTER_CYCLES = TIMER_W'(OL_FILTER_CYC)
)
(
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Serial pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic csN,
   output logic miso,
   output logic misoOe,
   // Supply monitors
   input wire logic uvLogic,
   input wire logic uvBattery,
   input wire logic overvoltageFlag,
   input wire logic lowBattery,
   input wire logic sleep,
   input wire logic trimSet,
   // Fault sources
   input wire logic [NUM_OSS-1:0] outOn,
   input wire logic [NUM_OSS-1:0] olComp,
   input wire logic [NUM_OSS-1:0] tlimOss,
   input wire logic tlimDrv1,
   // Pull-down control from the wider command set
   input wire logic pdWriteStb,
   input wire logic [NUM_OSS-1:0] pdWriteMask,
   // Driver controls
   output logic outputsEnable,
   output logic [NUM_OSS-1:0] pullDownEn,
   output logic driverTwoRetryEnable,
   output logic [AMP_W-1:0] ditherAmplitude,
   output logic [FREQ_W-1:0] ditherFrequency,
   output logic [CTRL_W-1:0] driverTwoCtrl
);

   // ----------------------------------------------------------------
   // Command decode helpers
   // ----------------------------------------------------------------
   function automatic logic [CMD_W-1:0] cmdOf(input logic [FRAME_W-1:0] w);
      cmdOf = w[CMD_HI:CMD_LO];
   endfunction

   function automatic logic isUnused(input logic [CMD_W-1:0] c);
      isUnused = (c == CMD_INVALID_A) || (c == CMD_INVALID_B);
   endfunction

   // ----------------------------------------------------------------
   // Serial shifter and open-load timer
   // ----------------------------------------------------------------
   logic [FRAME_W-1:0] loadWord, frameWord;
   logic csFall, csRise, frameDone, olArmed;
   logic ctrlRst, uvAny;

   dfcd_spi_shift u_shift (
      .clock(clock),
      .rst_n(rst_n),
      .sclk(sclk),
      .mosi(mosi),
      .csN(csN),
      .miso(miso),
      .misoOe(misoOe),
      .loadWord(loadWord),
      .csFall(csFall),
      .csRise(csRise),
      .frameDone(frameDone),
      .frameWord(frameWord)
   );

   dfcd_ol_filter #(
      .FILTER_CYCLES(OL_FILTER_CYCLES)
   ) u_filter (
      .clock(clock),
      .rst_n(rst_n),
      .csRise(csRise),
      .armed(olArmed)
   );

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic retry_q, retry_d;
   logic [AMP_W-1:0] amp_q, amp_d;
   logic [FREQ_W-1:0] freq_q, freq_d;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [NUM_OSS-1:0] pdEn_q, pdEn_d;
   dfcd_resp_t respSel_q, respSel_d;
   logic [CMD_W-1:0] rxCmd;

   assign uvAny = uvLogic | uvBattery;
   // Under-voltage acts like a reset on every control register
   assign ctrlRst = !rst_n || uvAny;
   assign rxCmd = cmdOf(frameWord);

   always_comb begin
      retry_d = retry_q;
      amp_d = amp_q;
      freq_d = freq_q;
      ctrl_d = ctrl_q;
      pdEn_d = pdEn_q;
      respSel_d = respSel_q;
      if (frameDone) begin
         respSel_d = DFCD_RESP_NORMAL;
         case (rxCmd)
            CMD_DRV2_DITHER: begin
               retry_d = frameWord[RETRY_BIT];
               amp_d = frameWord[AMP_HI:AMP_LO];
               freq_d = frameWord[FREQ_HI:FREQ_LO];
            end
            CMD_DRV2_CTRL: begin
               ctrl_d = frameWord[CTRL_W-1:0];
            end
            CMD_THERMAL_LIMIT_QUERY: begin
               respSel_d = DFCD_RESP_THERMAL_LIMIT;
            end
            default: begin
               // Unused and foreign codes touch nothing; the next answer is the normal word
               respSel_d = DFCD_RESP_NORMAL;
            end
         endcase
      end
      // Pull-downs drop only for sleep or an explicit serial disable
      if (sleep) begin
         pdEn_d = '0;
      end else if (pdWriteStb) begin
         pdEn_d = ~pdWriteMask;
      end
   end

   always_ff @(posedge clock) begin
      if (ctrlRst) begin
         retry_q <= 1'b0;
         amp_q <= '0;
         freq_q <= '0;
         ctrl_q <= CTRL_RESET;
         pdEn_q <= PD_RESET;
         respSel_q <= DFCD_RESP_NORMAL;
      end else begin
         retry_q <= retry_d;
         amp_q <= amp_d;
         freq_q <= freq_d;
         ctrl_q <= ctrl_d;
         pdEn_q <= pdEn_d;
         respSel_q <= respSel_d;
      end
   end

   // ----------------------------------------------------------------
   // Open-load latch
   // ----------------------------------------------------------------
   logic [NUM_OSS-1:0] olLatch_q, olLatch_d;
   logic [NUM_OSS-1:0] olShipped_q, olShipped_d;
   logic [NUM_OSS-1:0] olSet, olStatus;

   // Comparator result counts only for an off output with its pull-down on
   assign olSet = olArmed ? (olComp & ~outOn & pdEn_q) : '0;
   assign olStatus = olLatch_q & pdEn_q;

   always_comb begin
      olShipped_d = olShipped_q;
      olLatch_d = olLatch_q;
      if (csFall) begin
         olShipped_d = (respSel_q == DFCD_RESP_NORMAL) ? olStatus : '0;
      end
      // Clear only what the host has seen; a new set in the same cycle wins
      if (frameDone) begin
         olLatch_d = olLatch_q & ~olShipped_q;
      end
      olLatch_d = olLatch_d | olSet;
   end

   always_ff @(posedge clock) begin
      if (ctrlRst) begin
         olLatch_q <= '0;
         olShipped_q <= '0;
      end else begin
         olLatch_q <= olLatch_d;
         olShipped_q <= olShipped_d;
      end
   end

   // ----------------------------------------------------------------
   // Response word
   // ----------------------------------------------------------------
   logic anyTlim;
   logic [FRAME_W-1:0] normalWord, tlimWord;

   assign anyTlim = tlimDrv1 | (|tlimOss);

   always_comb begin
      normalWord = '0;
      normalWord[RESP_FAULT_BIT] = overvoltageFlag | anyTlim;
      normalWord[RESP_TRIM_BIT] = trimSet;
      normalWord[RESP_OL_LO +: NUM_OSS] = olStatus;
      tlimWord = '0;
      tlimWord[THERMAL_LIMIT_DRV1_BIT] = tlimDrv1;
      tlimWord[THERMAL_LIMIT_OSS_LO +: NUM_OSS] = tlimOss;
   end

   assign loadWord = (respSel_q == DFCD_RESP_THERMAL_LIMIT) ? tlimWord : normalWord;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic outEn_q, outEn_d;

   // Low battery is not a shutdown cause; status may be unreliable then
   assign outEn_d = !uvAny && !overvoltageFlag;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         outEn_q <= 1'b0;
      end else begin
         outEn_q <= outEn_d;
      end
   end

   assign outputsEnable = outEn_q;
   assign pullDownEn = pdEn_q;
   assign driverTwoRetryEnable = retry_q;
   assign ditherAmplitude = amp_q;
   assign ditherFrequency = freq_q;
   assign driverTwoCtrl = ctrl_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_ditherFrame;
      frameDone && rxCmd == CMD_DRV2_DITHER && !uvAny;
   endsequence

   sequence s_csRelease;
      csRise;
   endsequence

   property p_dither;
      @(posedge clock) disable iff (!rst_n)
      s_ditherFrame |=> retry_q == $past(frameWord[RETRY_BIT]) && amp_q == $past(frameWord[AMP_HI:AMP_LO]);
   endproperty
   a_dither: assert property (p_dither) else $error("dither command not stored");

   property p_thermal_limit;
      @(posedge clock) disable iff (!rst_n)
      frameDone && rxCmd == CMD_THERMAL_LIMIT_QUERY && !uvAny |=> respSel_q == DFCD_RESP_THERMAL_LIMIT &&
         loadWord[THERMAL_LIMIT_DRV1_BIT] == tlimDrv1 && loadWord[THERMAL_LIMIT_OSS_LO +: NUM_OSS] == tlimOss;
   endproperty
   a_thermal_limit: assert property (p_thermal_limit) else $error("thermal answer wrong");

   property p_ovBit;
      @(posedge clock) disable iff (!rst_n)
      respSel_q == DFCD_RESP_NORMAL && overvoltageFlag |-> loadWord[RESP_FAULT_BIT];
   endproperty
   a_ovBit: assert property (p_ovBit) else $error("over-voltage bit clear");

   property p_trim;
      @(posedge clock) disable iff (!rst_n)
      respSel_q == DFCD_RESP_NORMAL |-> loadWord[RESP_TRIM_BIT] == trimSet;
   endproperty
   a_trim: assert property (p_trim) else $error("trim bit wrong");

   property p_olOffOnly;
      @(posedge clock) disable iff (ctrlRst)
      ##1 ((olLatch_q & ~$past(olLatch_q)) & $past(outOn)) == '0;
   endproperty
   a_olOffOnly: assert property (p_olOffOnly) else $error("open load set on active output");

   property p_pdZero;
      @(posedge clock) disable iff (!rst_n)
      respSel_q == DFCD_RESP_NORMAL |-> (loadWord[RESP_OL_LO +: NUM_OSS] & ~pdEn_q) == '0;
   endproperty
   a_pdZero: assert property (p_pdZero) else $error("open load shown with pull-down off");

   property p_pdOnly;
      @(posedge clock) disable iff (ctrlRst)
      ##1 (($past(pdEn_q) & ~pdEn_q) != '0) |-> $past(sleep) || $past(pdWriteStb);
   endproperty
   a_pdOnly: assert property (p_pdOnly) else $error("pull-down dropped without cause");

   property p_filter;
      @(posedge clock) disable iff (!rst_n)
      s_csRelease |=> !olArmed [*8];
   endproperty
   a_filter: assert property (p_filter) else $error("comparator enabled before delay");

   property p_latch;
      @(posedge clock) disable iff (ctrlRst)
      !frameDone |=> ($past(olLatch_q) & ~olLatch_q) == '0;
   endproperty
   a_latch: assert property (p_latch) else $error("open load lost before read");

   property p_uv;
      @(posedge clock) disable iff (!rst_n)
      uvAny |=> !outputsEnable && !driverTwoRetryEnable && pullDownEn == PD_RESET;
   endproperty
   a_uv: assert property (p_uv) else $error("under-voltage not shut down");

   property p_ov;
      @(posedge clock) disable iff (!rst_n)
      overvoltageFlag |=> !outputsEnable;
   endproperty
   a_ov: assert property (p_ov) else $error("over-voltage not shut down");

   property p_lowBat;
      @(posedge clock) disable iff (!rst_n)
      lowBattery && !uvAny && !overvoltageFlag |=> outputsEnable;
   endproperty
   a_lowBat: assert property (p_lowBat) else $error("low battery shut outputs");

   property p_unused;
      @(posedge clock) disable iff (!rst_n)
      frameDone && isUnused(rxCmd) && !uvAny |=> $stable(retry_q) && $stable(ctrl_q) && $stable(freq_q);
   endproperty
   a_unused: assert property (p_unused) else $error("unused command changed state");

endmodule

`default_nettype wire

//--- driver_fault_command_decode_tb.sv
// Testbench for the driver fault command decoder.
// Assumes the host model drives the serial pins; supplies and faults driven here.

`timescale 1ns/1ps
`default_nettype none

module driver_fault_command_decode_tb;
   import dfcd_pkg::*;

   logic clock = 1'b0;
   logic rst_n;
   logic sclk, mosi, csN, miso, misoOe;
   logic uvLogic, uvBattery, overvoltageFlag;
   logic lowBattery, sleep, trimSet;
   logic [7:0] outOn, olComp, tlimOss;
   logic tlimDrv1, pdWriteStb;
   logic [7:0] pdWriteMask;
   logic outputsEnable, driverTwoRetryEnable;
   logic [7:0] pullDownEn;
   logic [2:0] ditherAmplitude;
   logic [3:0] ditherFrequency;
   logic [10:0] driverTwoCtrl;
   logic [15:0] resp;
   logic [19:0] ctrlAll;
   int failCount = 0, checksDone = 0, cycles = 0;

   assign ctrlAll = {1'b0, driverTwoRetryEnable, ditherAmplitude, ditherFrequency, driverTwoCtrl};

   always #4 clock = ~clock;

   dfcd_host_model host (.clock(clock), .sclk(sclk), .mosi(mosi), .csN(csN), .miso(miso));

   // Short filter so open-load timing fits a brief run
   dfcd_top #(.OL_FILTER_CYCLES(16'h0014)) dut (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .mosi(mosi), .csN(csN), .miso(miso),
      .misoOe(misoOe), .uvLogic(uvLogic), .uvBattery(uvBattery), .overvoltageFlag(overvoltageFlag),
      .lowBattery(lowBattery), .sleep(sleep), .trimSet(trimSet), .outOn(outOn), .olComp(olComp),
      .tlimOss(tlimOss), .tlimDrv1(tlimDrv1), .pdWriteStb(pdWriteStb), .pdWriteMask(pdWriteMask),
      .outputsEnable(outputsEnable), .pullDownEn(pullDownEn), .driverTwoRetryEnable(driverTwoRetryEnable),
      .ditherAmplitude(ditherAmplitude), .ditherFrequency(ditherFrequency), .driverTwoCtrl(driverTwoCtrl)
   );

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic finalReport();
      $display("checks %0d, mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic frame(input logic [15:0] cmd);
      host.xfer(cmd, 16, resp);
   endtask

   task automatic pdWrite(input logic [7:0] mask);
      pdWriteMask = mask;
      pdWriteStb = 1'b1;
      host.tick(1);
      pdWriteStb = 1'b0;
      host.tick(2);
   endtask

   // Hang guard: whole sequence needs well under this many cycles
   always @(posedge clock) begin
      // Serial output is driven exactly while the chip is selected
      check({19'h0, misoOe}, {19'h0, !csN});
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         finalReport();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      uvLogic = 1'b0;
      uvBattery = 1'b0;
      overvoltageFlag = 1'b0;
      lowBattery = 1'b0;
      sleep = 1'b0;
      trimSet = 1'b1;
      outOn = 8'h00;
      olComp = 8'h00;
      tlimOss = 8'h00;
      tlimDrv1 = 1'b0;
      pdWriteStb = 1'b0;
      pdWriteMask = 8'h00;
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      host.tick(2);
      check({19'h0, outputsEnable}, 20'h1);
      check({12'h0, pullDownEn}, 20'h000ff);
      check(ctrlAll, 20'h0);
      frame({CMD_DRV2_DITHER, 11'h45a});
      frame({CMD_DRV2_CTRL, 11'h2c3});
      check(ctrlAll, 20'h6d2c3);
      // Unused codes and a short frame must leave every register alone
      frame({CMD_INVALID_A, 11'h7ff});
      frame({CMD_INVALID_B, 11'h000});
      host.xfer({CMD_DRV2_DITHER, 11'h000}, 15, resp);
      check(ctrlAll, 20'h6d2c3);
      // Thermal query answer arrives in the next frame
      tlimOss = 8'ha5;
      tlimDrv1 = 1'b1;
      frame({CMD_THERMAL_LIMIT_QUERY, 11'h000});
      frame(16'h0000);
      check({4'h0, resp}, 20'h0034a);
      frame(16'h0000);
      check({4'h0, resp}, 20'h0c000);
      tlimOss = 8'h00;
      tlimDrv1 = 1'b0;
      trimSet = 1'b0;
      frame(16'h0000);
      check({4'h0, resp}, 20'h00000);
      overvoltageFlag = 1'b1;
      host.tick(2);
      check({19'h0, outputsEnable}, 20'h0);
      frame(16'h0000);
      check({4'h0, resp}, 20'h08000);
      overvoltageFlag = 1'b0;
      host.tick(2);
      check({19'h0, outputsEnable}, 20'h1);
      frame(16'h0000);
      check({4'h0, resp}, 20'h00000);
      // Open-load glitch inside the delay after chip-select release is not reported
      olComp = 8'h01;
      host.tick(5);
      olComp = 8'h00;
      host.tick(40);
      frame(16'h0000);
      check({4'h0, resp}, 20'h00000);
      // Output commanded on is not checked; off output latches
      outOn = 8'h02;
      olComp = 8'h03;
      host.tick(40);
      olComp = 8'h00;
      frame(16'h0000);
      check({4'h0, resp}, 20'h00001);
      frame(16'h0000);
      check({4'h0, resp}, 20'h00000);
      // Latch an open load, then drop its pull-down: the bit must read zero
      olComp = 8'h01;
      host.tick(40);
      olComp = 8'h00;
      pdWrite(8'h01);
      check({12'h0, pullDownEn}, 20'h000fe);
      frame(16'h0000);
      check({4'h0, resp}, 20'h00000);
      sleep = 1'b1;
      host.tick(2);
      check({12'h0, pullDownEn}, 20'h00000);
      sleep = 1'b0;
      pdWrite(8'h00);
      // Low battery keeps commands working; the unread open load shows again
      lowBattery = 1'b1;
      frame({CMD_DRV2_DITHER, 11'h45a});
      check({4'h0, resp}, 20'h00001);
      check({19'h0, outputsEnable}, 20'h1);
      check(ctrlAll, 20'h6d2c3);
      lowBattery = 1'b0;
      // Either under-voltage clears controls and shuts outputs
      for (int k = 0; k < 2; k++) begin
         frame({CMD_DRV2_DITHER, 11'h45a});
         pdWrite(8'h0f);
         uvLogic = (k == 0);
         uvBattery = (k == 1);
         host.tick(2);
         check({19'h0, outputsEnable}, 20'h0);
         check(ctrlAll, 20'h0);
         check({12'h0, pullDownEn}, 20'h000ff);
         uvLogic = 1'b0;
         uvBattery = 1'b0;
         host.tick(2);
         check({19'h0, outputsEnable}, 20'h1);
      end
      finalReport();
   end

endmodule

`default_nettype wire
